// ### inc/dmh_pkg.sv
package dmh_pkg;

	// Register offsets
	localparam logic [3:0] REG_CMD = 4'h0;
	localparam logic [3:0] REG_MODE_LO = 4'h1;
	localparam logic [3:0] REG_MODE_HI = 4'h2;
	localparam logic [3:0] REG_CASC = 4'h3;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_PREEMPT = 4'h5;
	localparam logic [3:0] REG_TIMEOUT = 4'h6;

	// Command register fields and reset values
	localparam int CMD_REQ_LOW_BIT = 6;
	localparam int CMD_ACK_LOW_BIT = 7;
	localparam logic [7:0] CMD_RST = 8'h00;
	localparam logic [15:0] MODE_RST = 16'h0000;
	localparam logic [7:0] CASC_RST = 8'h00;

	// Status register fields
	localparam int STAT_BUSY_BIT = 7;

	// Channels present: 0..3 and 5..7
	localparam logic [7:0] CH_MASK = 8'hEF;
	localparam logic [3:0] SLOT_BASE = 4'h8;

	// Timing types of a DMA channel
	localparam logic [1:0] TM_COMPAT = 2'h0;
	localparam logic [1:0] TM_TYPE_A = 2'h1;
	localparam logic [1:0] TM_TYPE_B = 2'h2;
	localparam logic [1:0] TM_BURST = 2'h3;

	// Bus clocks per transfer for each timing type
	localparam logic [7:0] LEN_COMPAT = 8'h08;
	localparam logic [7:0] LEN_TYPE_A = 8'h06;
	localparam logic [7:0] LEN_TYPE_B = 8'h04;
	localparam logic [7:0] LEN_BURST = 8'h01;

	// Clocks between request sample and ready sample, and cascade drop countdown
	localparam logic [7:0] LEAD_AB = 8'h02;
	localparam logic [7:0] LEAD_B = 8'h01;
	localparam logic [7:0] CASC_DROP = 8'h01;

	// Times and derived clock counts
	localparam int CLK_PERIOD_NS = 100;
	localparam int PREEMPT_NS = 4000;
	localparam int MREL_NS = 8000;
	localparam int PREEMPT_CYC = (PREEMPT_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;
	localparam int MREL_CYC = MREL_NS / CLK_PERIOD_NS;

	// Arbiter states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DMA,
		ST_CASC,
		ST_CDROP,
		ST_MST,
		ST_MPRE,
		ST_MEND
	} dmh_state_t;

	// Register port request
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} dmh_reg_req_t;

endpackage : dmh_pkg

// ### verilog/dmh_req_sync.sv
`timescale 1ns/1ns
module dmh_req_sync import dmh_pkg::*; #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// Asynchronous levels in, synchronised levels out
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} dmh_sync_st_t;

	dmh_sync_st_t st_r;
	dmh_sync_st_t st_nxt;

	// Two flops; only the second stage is read outside
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = async_i;
		st_nxt.s2 = st_r.s1;
	end

	// State register
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign sync_o = st_r.s2;

endmodule : dmh_req_sync

// ### verilog/dmh_arbiter.sv
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
// Behaviour
// - Seven DMA request inputs and acknowledge outputs
// - Command bit 6 selects request polarity
// - Request assertion synchronised before use
// - Cascade request sampled two clocks before release
// - Compat/A sample two clocks before ready
// - Type B sample one clock before ready
// - Burst sample right after address change
// - Command bit 7 selects acknowledge polarity
// - Non-compatible channel preempted after 4 us
// - Preempted channel resumes when winning again
// - Acknowledges inactive during reset
// - Six active-low synchronous master requests
// - Last cycle end seen on cycle-in-progress
// - Master acknowledge held until request inactive
// - Acknowledge withdrawn early; 8 us release limit
module dmh_arbiter import dmh_pkg::*; (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// Register port
	input wire dmh_reg_req_t reg_req_i,
	output logic [7:0] reg_rdata_o,
	// DMA request and acknowledge, bit 4 unused
	input wire logic [7:0] dreq_i,
	output logic [7:0] dack_o,
	// Transfer timing
	input wire logic dma_ready_i,
	output logic addr_strobe_o,
	// Slot master request and acknowledge
	input wire logic [5:0] mreq_n_i,
	output logic [5:0] mack_n_o,
	input wire logic cycle_in_progress_n_i
);

	typedef struct packed {
		logic [7:0] cmd;
		logic [15:0] mode;
		logic [7:0] casc;
		logic [7:0] pre;
		logic [5:0] tmo;
		dmh_state_t state;
		logic [3:0] owner;
		logic [7:0] cnt;
		logic [7:0] pcnt;
		logic endreq;
		// Preempted owner skips the next pick
		logic yld;
		logic [7:0] ack;
		logic [5:0] mack;
		logic [7:0] dack;
		logic [5:0] mack_n;
		logic addr_stb;
		logic [7:0] rdata;
	} dmh_st_t;

	dmh_st_t r;
	dmh_st_t n;

	logic [7:0] req_pol;
	logic [7:0] req_s;
	logic [7:0] req_raw;
	logic [13:0] pend;
	logic [13:0] own_mask;
	logic other;
	logic [4:0] win;

	// Timing type of one channel
	function automatic logic [1:0] mode_of(input logic [15:0] m,
		input logic [2:0] ch);
		mode_of = m[{ch, 1'b0} +: 2];
	endfunction : mode_of

	// Index of the ready-sampling clock in a transfer
	function automatic logic [7:0] last_idx(input logic [1:0] md);
		case (md)
			TM_COMPAT: last_idx = LEN_COMPAT - 8'h01;
			TM_TYPE_A: last_idx = LEN_TYPE_A - 8'h01;
			TM_TYPE_B: last_idx = LEN_TYPE_B - 8'h01;
			default: last_idx = LEN_BURST - 8'h01;
		endcase
	endfunction : last_idx

	// Index of the request-sampling clock in a transfer
	function automatic logic [7:0] samp_idx(input logic [1:0] md);
		case (md)
			TM_COMPAT: samp_idx = last_idx(md) - LEAD_AB;
			TM_TYPE_A: samp_idx = last_idx(md) - LEAD_AB;
			TM_TYPE_B: samp_idx = last_idx(md) - LEAD_B;
			default: samp_idx = 8'h00;
		endcase
	endfunction : samp_idx

	// Fixed priority pick, lowest index wins; bit 4 is found flag
	function automatic logic [4:0] pick(input logic [13:0] p);
		pick = 5'h00;
		for (int i = 13; i >= 0; i--) begin
			if (p[i]) begin
				pick = {1'b1, 4'(i)};
			end
		end
	endfunction : pick

	// Polarity applied ahead of the synchroniser
	assign req_pol = dreq_i ^ {8{r.cmd[CMD_REQ_LOW_BIT]}};
	assign req_raw = req_pol & CH_MASK;

	dmh_req_sync #(
		.W(8)
	) u_req_sync (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.async_i(req_pol),
		.sync_o(req_s)
	);

	// Pending requests in priority order and rivals of the owner
	assign pend = {~mreq_n_i, req_s & CH_MASK};
	assign own_mask = 14'(14'h0001 << r.owner);
	assign other = |(pend & ~own_mask);
	// A channel that was just preempted sits out one arbitration,
	// otherwise its fixed priority would hand it the bus straight back
	assign win = pick(r.yld ? (pend & ~own_mask) : pend);

	// Next state
	always_comb begin
		logic [1:0] md;
		logic [2:0] ch;
		logic [2:0] slot;
		logic smp;
		logic endq;
		logic pexp;
		md = 2'h0;
		ch = r.owner[2:0];
		slot = 3'(r.owner - SLOT_BASE);
		smp = 1'b0;
		endq = 1'b0;
		pexp = 1'b0;
		n = r;
		n.addr_stb = 1'b0;
		n.rdata = 8'h00;

		// Register writes; clears come first so that sets below win
		if (reg_req_i.wr) begin
			case (reg_req_i.addr)
				REG_CMD: n.cmd = reg_req_i.wdata;
				REG_MODE_LO: n.mode[7:0] = reg_req_i.wdata;
				REG_MODE_HI: n.mode[15:10] = reg_req_i.wdata[5:0];
				REG_CASC: n.casc = reg_req_i.wdata & CH_MASK;
				REG_PREEMPT: n.pre = r.pre & ~reg_req_i.wdata;
				REG_TIMEOUT: n.tmo = r.tmo & ~reg_req_i.wdata[5:0];
				default: n.cmd = r.cmd;
			endcase
		end

		// Register reads, answered next cycle
		if (reg_req_i.rd) begin
			case (reg_req_i.addr)
				REG_CMD: n.rdata = r.cmd;
				REG_MODE_LO: n.rdata = r.mode[7:0];
				REG_MODE_HI: n.rdata = {2'h0, r.mode[15:10]};
				REG_CASC: n.rdata = r.casc;
				REG_STATUS: n.rdata = {r.state != ST_IDLE, 3'h0,
					r.owner};
				REG_PREEMPT: n.rdata = r.pre;
				REG_TIMEOUT: n.rdata = {2'h0, r.tmo};
				default: n.rdata = 8'h00;
			endcase
		end

		// Arbitration and handshake
		case (r.state)
			ST_IDLE: begin
				// The sit-out lasts one idle cycle only
				n.yld = 1'b0;
				if (win[4]) begin
					n.owner = win[3:0];
					n.cnt = 8'h00;
					n.pcnt = 8'h00;
					n.endreq = 1'b0;
					if (win[3:0] < SLOT_BASE) begin
						n.ack[win[2:0]] = 1'b1;
						if (r.casc[win[2:0]]) begin
							n.state = ST_CASC;
						end else begin
							n.state = ST_DMA;
							n.addr_stb = 1'b1;
						end
					end else begin
						n.mack[3'(win[3:0] - SLOT_BASE)] = 1'b1;
						n.state = ST_MST;
					end
				end
			end
			ST_DMA: begin
				md = mode_of(r.mode, ch);
				// Preemption clock runs while a rival waits; it stays at zero for compatible timing
				if (!other || md == TM_COMPAT) begin
					n.pcnt = 8'h00;
				end else if (r.pcnt != 8'(PREEMPT_CYC)) begin
					n.pcnt = r.pcnt + 8'h01;
				end
				pexp = (r.pcnt == 8'(PREEMPT_CYC));
				if (r.cnt == samp_idx(md)) begin
					// Burst requests are already synchronous
					smp = (md == TM_BURST) ? req_raw[ch] : req_s[ch];
					endq = !smp;
				end
				endq = endq | r.endreq;
				n.endreq = endq;
				if (r.cnt == last_idx(md)) begin
					if (dma_ready_i) begin
						if (endq || pexp) begin
							n.ack[ch] = 1'b0;
							n.state = ST_IDLE;
							if (!endq) begin
								n.pre[ch] = 1'b1;
								// Rival gets the next arbitration
								n.yld = 1'b1;
							end
						end else begin
							n.cnt = 8'h00;
							n.addr_stb = 1'b1;
						end
					end
				end else begin
					n.cnt = r.cnt + 8'h01;
				end
			end
			ST_CASC: begin
				if (!req_s[ch]) begin
					n.cnt = CASC_DROP;
					n.state = ST_CDROP;
				end
			end
			ST_CDROP: begin
				if (r.cnt == 8'h00) begin
					n.ack[ch] = 1'b0;
					n.state = ST_IDLE;
				end else begin
					n.cnt = r.cnt - 8'h01;
				end
			end
			ST_MST: begin
				if (mreq_n_i[slot]) begin
					n.mack[slot] = 1'b0;
					n.state = ST_MEND;
				end else if (other) begin
					n.mack[slot] = 1'b0;
					n.pcnt = 8'h00;
					n.state = ST_MPRE;
				end
			end
			ST_MPRE: begin
				n.pcnt = r.pcnt + 8'h01;
				if (mreq_n_i[slot]) begin
					n.state = ST_MEND;
				end else if (r.pcnt == 8'(MREL_CYC - 1)) begin
					n.tmo[slot] = 1'b1;
					n.state = ST_MEND;
				end
			end
			ST_MEND: begin
				if (!cycle_in_progress_n_i) begin
					n.state = ST_IDLE;
				end
			end
			default: n.state = ST_IDLE;
		endcase

		// Output levels
		n.dack = (n.ack & CH_MASK) ^ {8{n.cmd[CMD_ACK_LOW_BIT]}};
		n.mack_n = ~n.mack;
	end

	// State register; reset leaves every acknowledge inactive
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			r <= '0;
			r.mack_n <= '1;
		end else begin
			r <= n;
		end
	end

	// Outputs straight from flops
	assign reg_rdata_o = r.rdata;
	assign dack_o = r.dack;
	assign addr_strobe_o = r.addr_stb;
	assign mack_n_o = r.mack_n;

endmodule : dmh_arbiter

// ### bench/dmh_arbiter_checker.sv
`timescale 1ns/1ns
module dmh_arbiter_checker import dmh_pkg::*; (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// Watched ports
	input wire logic [7:0] dack_o,
	input wire logic addr_strobe_o,
	input wire logic [5:0] mreq_n_i,
	input wire logic [5:0] mack_n_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// Ownership and grant relations
	property p_rst;
		disable iff (1'b0) rst_i |-> dack_o == 8'h00 && mack_n_o == 6'h3F;
	endproperty
	a_rst: assert property (p_rst) else $error("ack in reset");
	property p_one;
		$onehot0(dack_o) || $onehot0(~dack_o);
	endproperty
	a_one: assert property (p_one) else $error("two dack");
	property p_excl;
		mack_n_o != 6'h3F |-> dack_o == 8'h00 || dack_o == 8'hFF;
	endproperty
	a_excl: assert property (p_excl) else $error("dack and mack");
	property p_mone;
		$onehot0(~mack_n_o);
	endproperty
	a_mone: assert property (p_mone) else $error("two mack");
	property p_mgnt;
		($past(mack_n_o) & ~mack_n_o & $past(mreq_n_i)) == 6'h00;
	endproperty
	a_mgnt: assert property (p_mgnt) else $error("mack unasked");
	property p_mrel;
		(~mack_n_o & mreq_n_i) != 6'h00 |=> mack_n_o == 6'h3F;
	endproperty
	a_mrel: assert property (p_mrel) else $error("mack held");
	// A grant withdrawn while its request stands keeps the bus quiet
	property p_mmin;
		($past(~mack_n_o) & mack_n_o & ~mreq_n_i) != 6'h00 |=>
			mack_n_o == 6'h3F && (dack_o == 8'h00 || dack_o == 8'hFF);
	endproperty
	a_mmin: assert property (p_mmin) else $error("mack short");
	property p_strb;
		addr_strobe_o |-> dack_o != 8'h00 && dack_o != 8'hFF;
	endproperty
	a_strb: assert property (p_strb) else $error("strobe no dack");
	// Main scenarios
	c_dma: cover property (addr_strobe_o);
	c_mst: cover property (mack_n_o != 6'h3F);
	c_low: cover property (dack_o == 8'hDF);
endmodule : dmh_arbiter_checker
bind dmh_arbiter dmh_arbiter_checker dmh_arbiter_checker_i (
	.sys_clk_i(sys_clk_i),
	.rst_i(rst_i),
	.dack_o(dack_o),
	.addr_strobe_o(addr_strobe_o),
	.mreq_n_i(mreq_n_i),
	.mack_n_o(mack_n_o)
);

// ### bench/dmh_partner.sv
`timescale 1ns/1ns
module dmh_partner import dmh_pkg::*; (
	// Clock and bench controls
	input wire logic sys_clk_i,
	input wire logic [7:0] dset_i,
	input wire logic [5:0] mset_i,
	input wire logic hold_i,
	input wire logic low_i,
	input wire logic slow_i,
	// Arbiter side
	input wire logic [7:0] dack_i,
	input wire logic [5:0] mack_n_i,
	output logic [7:0] dreq_o,
	output logic [5:0] mreq_n_o,
	output logic cip_n_o,
	output logic ready_o
);
	logic [7:0] dp = 8'h00;
	logic [5:0] mp = 6'h00;
	logic [3:0] mc = 4'h0;
	logic cd = 1'b0;
	logic cp = 1'b1;
	logic ry = 1'b1;
	// Slave keeps its request until acknowledged, clocked synchronously
	always @(posedge sys_clk_i) begin
		dp <= (dp | dset_i) & ~((dack_i ^ {8{low_i}}) & ~{8{hold_i}});
		ry <= slow_i ? ~ry : 1'b1;
	end
	assign dreq_o = dp ^ {8{low_i}};
	assign ready_o = ry;
	assign cip_n_o = cp;
	// Master moves on falling edges, gives up 15 clocks after its grant;
	// no new request while its last command strobe is still settling
	always @(negedge sys_clk_i) begin
		if (!cd && cp) begin
			mp <= mp | mset_i;
		end
		cp <= ~cd;
		cd <= 1'b0;
		if (mc != 4'h0 || (mp & ~mack_n_i) != 6'h00) begin
			mc <= mc + 4'h1;
		end
		if (mc == 4'hF) begin
			mp <= 6'h00;
			cd <= 1'b1;
		end
	end
	assign mreq_n_o = ~mp;
endmodule : dmh_partner

// ### bench/dmh_arbiter_bench.sv
`timescale 1ns/1ns
module dmh_arbiter_bench import dmh_pkg::*; ;
	logic sys_clk = 1'b0;
	logic rst = 1'b0;
	dmh_reg_req_t rq = '0;
	logic [7:0] rdata, dreq, dack, nd, ns, t, ds = 8'h00;
	logic [5:0] mreq_n, mack_n, mg = 6'h00;
	logic rdy, strb, cip_n, hold = 1'b0, lo = 1'b0, slow = 1'b0;
	logic [7:0] len [4] = '{LEN_COMPAT, LEN_TYPE_A, LEN_TYPE_B, LEN_BURST};
	int failures = 0;
	int n_checks = 0;
	initial begin
		forever #50 sys_clk = ~sys_clk;
	end
	dmh_arbiter dmh_arbiter_i (.sys_clk_i(sys_clk), .rst_i(rst),
		.reg_req_i(rq), .reg_rdata_o(rdata), .dreq_i(dreq), .dack_o(dack),
		.dma_ready_i(rdy), .addr_strobe_o(strb), .mreq_n_i(mreq_n),
		.mack_n_o(mack_n), .cycle_in_progress_n_i(cip_n));
	dmh_partner dmh_partner_i (.sys_clk_i(sys_clk), .dset_i(ds), .mset_i(mg),
		.hold_i(hold), .low_i(lo), .slow_i(slow), .dack_i(dack),
		.mack_n_i(mack_n), .dreq_o(dreq), .mreq_n_o(mreq_n), .cip_n_o(cip_n),
		.ready_o(rdy));
	// Verdict and end of run
	task test_done;
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : test_done
	task chk(input logic [13:0] s, input logic [13:0] e);
		n_checks++;
		if (s !== e) begin
			failures++;
			$display("ERROR %0t: got %h exp %h", $time, s, e);
		end
	endtask : chk
	// Register port cycles
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		rq <= '{a, d, 1'b1, 1'b0};
		@(posedge sys_clk);
		rq <= '0;
	endtask : wr
	task rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		rq <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge sys_clk);
		rq <= '0;
		@(posedge sys_clk);
		chk({6'h00, rdata}, {6'h00, e});
	endtask : rd
	// Start requests, wait for an acknowledge pattern
	task go(input logic [7:0] d, input logic [5:0] m);
		@(posedge sys_clk);
		ds <= d;
		mg <= m;
		@(posedge sys_clk);
		ds <= 8'h00;
		mg <= 6'h00;
	endtask : go
	task w(input logic [13:0] m, input int n);
		for (int i = 0; i < n && {mack_n, dack} !== m; i++) @(posedge sys_clk);
		chk({mack_n, dack}, m);
	endtask : w
	initial begin
		repeat (20000) @(posedge sys_clk);
		failures++;
		test_done;
	end
	initial begin
		// Rising reset at time zero clears every arbiter flop except mack_n, which it sets to ones, before the first edge
		rst <= 1'b1;
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		rd(REG_CMD, CMD_RST);
		rd(4'hF, 8'h00);
		// Each timing type: acknowledged clocks per address strobe
		for (t = 8'h00; t < 8'h04; t++) begin
			wr(REG_MODE_LO, t);
			go(8'h01, 6'h00);
			w({6'h3F, 8'h01}, 300);
			nd = 8'h00;
			ns = 8'h00;
			while (dack[0] === 1'b1 && nd < 8'h80) begin
				nd++;
				ns += {7'h00, strb};
				@(posedge sys_clk);
			end
			chk({6'h00, nd}, {6'h00, ns * len[t[1:0]]});
		end
		// Active-low request and acknowledge
		wr(REG_CMD, 8'hC0);
		lo <= 1'b1;
		go(8'h20, 6'h00);
		w({6'h3F, 8'hDF}, 300);
		w({6'h3F, 8'hFF}, 300);
		rd(REG_CMD, 8'hC0);
		wr(REG_CMD, CMD_RST);
		lo <= 1'b0;
		// Cascaded master on channel 2: two sync edges, then drop 2 later
		wr(REG_CASC, 8'h04);
		hold <= 1'b1;
		go(8'h04, 6'h00);
		w({6'h3F, 8'h04}, 300);
		rd(REG_CASC, 8'h04);
		hold <= 1'b0;
		repeat (6) @(posedge sys_clk);
		chk({mack_n, dack}, {6'h3F, 8'h04});
		@(posedge sys_clk);
		chk({mack_n, dack}, {6'h3F, 8'h00});
		wr(REG_CASC, 8'h00);
		// Slot master, then a DMA rival withdraws its grant
		go(8'h00, 6'h04);
		w({6'h3B, 8'h00}, 300);
		rd(REG_STATUS, 8'h8A);
		go(8'h08, 6'h00);
		w({6'h3F, 8'h00}, 6);
		w({6'h3F, 8'h08}, 300);
		rd(REG_TIMEOUT, 8'h00);
		// Type A channel preempted by a master, then resumed
		wr(REG_MODE_LO, 8'h04);
		hold <= 1'b1;
		slow <= 1'b1;
		go(8'h02, 6'h00);
		w({6'h3F, 8'h02}, 300);
		go(8'h00, 6'h01);
		repeat (30) @(posedge sys_clk);
		w({6'h3F, 8'h02}, 1);
		w({6'h3E, 8'h00}, 300);
		rd(REG_PREEMPT, 8'h02);
		wr(REG_PREEMPT, 8'h02);
		rd(REG_PREEMPT, 8'h00);
		w({6'h3F, 8'h02}, 300);
		hold <= 1'b0;
		w({6'h3F, 8'h00}, 300);
		test_done;
	end
endmodule : dmh_arbiter_bench
